// [src/adc_ctrl_pkg.sv]
// shared constants and types for the converter control block
package adc_ctrl_pkg;
    // register indices; the bus byte address is four times the index
    localparam logic [7:0] RESULT_IDX     = 8'h10;
    localparam logic [7:0] STATCTL_IDX    = 8'h11;
    localparam logic [7:0] IRQ_STAT_IDX   = 8'h12;
    localparam logic [7:0] IRQ_CLR_IDX    = 8'h13;
    localparam logic [7:0] IRQ_EN_IDX     = 8'h14;
    localparam logic [7:0] ANALOG_IDX     = 8'h15;
    // status/control field positions
    localparam int DONE_BIT  = 7;
    localparam int RCSEL_BIT = 6;
    localparam int PWR_BIT   = 5;
    localparam int CH_LSB    = 0;
    localparam logic [7:0] STATCTL_RESET = 8'h00;
    // timing counts in conversion clock cycles
    localparam int CONV_CYCLES   = 32;
    localparam int SAMPLE_CYCLES = 12;
    localparam logic [5:0] CONV_LAST   = 6'(CONV_CYCLES - 1);
    localparam logic [5:0] SAMPLE_LAST = 6'(SAMPLE_CYCLES - 1);
    // multiplexer codes
    localparam logic [2:0] CH_UPPER_REF = 3'h4;
    localparam logic [2:0] CH_MID_REF   = 3'h5;
    localparam logic [2:0] CH_LOWER_REF = 3'h6;
    localparam logic [2:0] CH_FACTORY   = 3'h7;

    typedef enum logic [1:0] {
        CLK_OFF,
        CLK_CPU,
        CLK_RC_WARM,
        CLK_RC
    } clk_mode_e;

    typedef struct packed {
        logic       done;
        logic       rc_sel;
        logic       power_on;
        logic [2:0] channel;
    } statctl_s;
endpackage

// [src/sar_adc_control.sv]
// control and status logic for an 8-bit successive-approximation converter
// Contract
// - one conversion lasts 32 cycles of the selected conversion clock.
// - on completion set done flag, load result, start next conversion immediately.
// - done flag cleared by result read, status/control write, or reset.
// - clock-select and power bits decode to off, cpu, rc warm-up, rc clock.
// - rc results cross to bus clock, at most one per bus cycle.
// - power bit enables converter; reset clears it.
// - channel codes 0-3 external, 4 upper, 5 mid, 6 lower ref, 7 test.
// - result register read-only, loaded from sar when flag sets.
// - converter keeps working normally during wait.
// - stop aborts any conversion and halts the converter.
// - sampling switch closed for first 12 cycles of each conversion.
// - any status/control write aborts, clears flag, restarts on new channel.
// - reset clears clock-select and power bits.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control
    import adc_ctrl_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    input  wire logic        RC_CLK_TICK,
    input  wire logic        WAIT_MODE,
    input  wire logic        STOP_MODE,
    input  wire logic        COMP_OUT,
    output logic             RC_OSC_ENABLE,
    output logic             SAMPLE_SWITCH,
    output logic [7:0]       DAC_CODE,
    output logic [6:0]       MUX_SELECT,
    output logic             IRQ,
    input  wire logic [31:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [31:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);

// ==========================================================
// input synchronisers
    logic [1:0] rc_sync_reg;
    logic [1:0] stop_sync_reg;
    logic [1:0] wait_sync_reg;
    logic       rc_last_reg;
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rc_sync_reg   <= 2'h0;
            stop_sync_reg <= 2'h0;
            wait_sync_reg <= 2'h0;
            rc_last_reg   <= 1'b0;
        end else begin
            rc_sync_reg   <= {rc_sync_reg[0], RC_CLK_TICK};
            stop_sync_reg <= {stop_sync_reg[0], STOP_MODE};
            wait_sync_reg <= {wait_sync_reg[0], WAIT_MODE};
            rc_last_reg   <= rc_sync_reg[1];
        end
    end
    // one rc edge per bus cycle at most, so results land on the bus clock
    logic rc_edge;
    assign rc_edge = rc_sync_reg[1] & ~rc_last_reg;

// ==========================================================
// axi4-lite slave
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        wr_fire;
    logic        rd_fire;
    logic [7:0]  rd_addr;
    assign S_AXI_AWREADY = ~aw_hold_reg & ~S_AXI_BVALID;
    assign S_AXI_WREADY  = ~w_hold_reg & ~S_AXI_BVALID;
    assign S_AXI_ARREADY = ~S_AXI_RVALID;
    assign wr_fire = aw_hold_reg & w_hold_reg;
    assign rd_fire = S_AXI_ARVALID & S_AXI_ARREADY;
    assign rd_addr = S_AXI_ARADDR[9:2];
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            aw_addr_reg  <= 8'h00;
            w_data_reg   <= 32'h0;
            w_strb_reg   <= 4'h0;
            S_AXI_BVALID <= 1'b0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR[9:2];
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                S_AXI_BVALID <= 1'b1;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end
    assign S_AXI_BRESP = 2'h0;
    assign S_AXI_RRESP = 2'h0;

    logic wr_ctl;
    logic wr_clr;
    logic wr_en;
    logic rd_result;
    // only byte lane 0 carries register data
    assign wr_ctl    = wr_fire && aw_addr_reg == STATCTL_IDX && w_strb_reg[0];
    assign wr_clr    = wr_fire && aw_addr_reg == IRQ_CLR_IDX && w_strb_reg[0];
    assign wr_en     = wr_fire && aw_addr_reg == IRQ_EN_IDX && w_strb_reg[0];
    assign rd_result = rd_fire && rd_addr == RESULT_IDX;

// ==========================================================
// status/control register
    statctl_s   ctl_reg;
    clk_mode_e  mode;
    logic       run;
    logic       conv_done;
    always_comb begin
        unique case ({ctl_reg.rc_sel, ctl_reg.power_on})
            2'b00: mode = CLK_OFF;
            2'b01: mode = CLK_CPU;
            2'b10: mode = CLK_RC_WARM;
            2'b11: mode = CLK_RC;
        endcase
    end
    // wait mode is deliberately not an input to run
    assign run = ctl_reg.power_on & ~stop_sync_reg[1];
    assign RC_OSC_ENABLE = ctl_reg.rc_sel & ~stop_sync_reg[1];

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctl_reg.done     <= STATCTL_RESET[DONE_BIT];
            ctl_reg.rc_sel   <= STATCTL_RESET[RCSEL_BIT];
            ctl_reg.power_on <= STATCTL_RESET[PWR_BIT];
            ctl_reg.channel  <= STATCTL_RESET[CH_LSB +: 3];
        end else begin
            if (wr_ctl) begin
                ctl_reg.rc_sel   <= w_data_reg[RCSEL_BIT];
                ctl_reg.power_on <= w_data_reg[PWR_BIT];
                ctl_reg.channel  <= w_data_reg[CH_LSB +: 3];
            end
            // write wins over completion since it restarts the conversion;
            // completion wins over a result read so a fresh result is never lost
            if (wr_ctl) begin
                ctl_reg.done <= 1'b0;
            end else if (conv_done) begin
                ctl_reg.done <= 1'b1;
            end else if (rd_result) begin
                ctl_reg.done <= 1'b0;
            end
        end
    end

// ==========================================================
// successive-approximation sequencer
    logic [5:0] cyc_reg;
    logic [7:0] sar_reg;
    logic [7:0] result_reg;
    logic       tick;
    assign tick = (mode == CLK_RC) ? rc_edge : 1'b1;
    assign conv_done = run && tick && cyc_reg == CONV_LAST && !wr_ctl;
    assign SAMPLE_SWITCH = run && cyc_reg <= SAMPLE_LAST;
    assign DAC_CODE = sar_reg;
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cyc_reg <= 6'h0;
            sar_reg <= 8'h80;
        end else if (!run || wr_ctl) begin
            cyc_reg <= 6'h0;
            sar_reg <= 8'h80;
        end else if (tick) begin
            if (cyc_reg == CONV_LAST) begin
                cyc_reg <= 6'h0;
                sar_reg <= 8'h80;
            end else begin
                cyc_reg <= cyc_reg + 6'h1;
                // bits resolve one per cycle after the sample phase; the comparator
                // answers our own dac code, so two sync flops would break the budget
                if (cyc_reg > SAMPLE_LAST && cyc_reg <= SAMPLE_LAST + 6'd8) begin
                    automatic logic [2:0] b = 3'(6'd7 - (cyc_reg - SAMPLE_LAST - 6'd1));
                    sar_reg[b] <= COMP_OUT;
                    if (b != 3'd0) begin
                        sar_reg[b - 3'd1] <= 1'b1;
                    end
                end
            end
        end
    end
    // result keeps no reset value; it is only defined once a conversion ends
    always_ff @(posedge CLOCK) begin
        if (conv_done) begin
            result_reg <= sar_reg;
        end
    end

    always_comb begin
        MUX_SELECT = 7'h0;
        // the factory test code connects no input
        if (SAMPLE_SWITCH && ctl_reg.channel != CH_FACTORY) begin
            MUX_SELECT = 7'h1 << ctl_reg.channel;
        end
    end

// ==========================================================
// interrupt status, clear and enable
    logic irq_stat_reg;
    logic irq_en_reg;
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            irq_stat_reg <= 1'b0;
            irq_en_reg   <= 1'b0;
        end else begin
            if (conv_done) begin
                irq_stat_reg <= 1'b1;
            end else if (wr_clr && w_data_reg[0]) begin
                irq_stat_reg <= 1'b0;
            end
            if (wr_en) begin
                irq_en_reg <= w_data_reg[0];
            end
        end
    end
    assign IRQ = irq_stat_reg & irq_en_reg;

// ==========================================================
// read channel
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0;
        end else if (rd_fire) begin
            S_AXI_RVALID <= 1'b1;
            unique case (rd_addr)
                RESULT_IDX:   S_AXI_RDATA <= {24'h0, result_reg};
                STATCTL_IDX:  S_AXI_RDATA <= {24'h0, ctl_reg.done, ctl_reg.rc_sel,
                                              ctl_reg.power_on, 2'b00, ctl_reg.channel};
                IRQ_STAT_IDX: S_AXI_RDATA <= {31'h0, irq_stat_reg};
                IRQ_EN_IDX:   S_AXI_RDATA <= {31'h0, irq_en_reg};
                ANALOG_IDX:   S_AXI_RDATA <= {26'h0, wait_sync_reg[1], mode == CLK_RC,
                                              SAMPLE_SWITCH, cyc_reg == 6'h0, run, tick};
                default:      S_AXI_RDATA <= 32'h0;
            endcase
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

// ==========================================================
// checks
    a_conv_period: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        conv_done |-> $past(cyc_reg) == CONV_LAST - 6'd1 || mode == CLK_RC)
        else $error("conversion length wrong");
    a_done_sets: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        conv_done |=> ctl_reg.done && cyc_reg == 6'h0)
        else $error("done flag not set or no restart");
    a_done_clears: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (wr_ctl || (rd_result && !conv_done)) |=> !ctl_reg.done)
        else $error("done flag not cleared");
    a_rc_gated: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (mode == CLK_RC && run && !rc_edge && !wr_ctl) |=> $stable(cyc_reg))
        else $error("rc mode advanced without rc edge");
    a_power_off: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (!ctl_reg.power_on && !wr_ctl) |=> cyc_reg == 6'h0 && !SAMPLE_SWITCH)
        else $error("converter active while off");
    a_result_load: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        conv_done |=> result_reg == $past(sar_reg))
        else $error("result not loaded from sar");
    a_stop_abort: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        stop_sync_reg[1] |=> cyc_reg == 6'h0 && !ctl_reg.done || $past(ctl_reg.done))
        else $error("conversion continued in stop");
    a_sample_span: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (run && cyc_reg == SAMPLE_LAST + 6'd1) |-> !SAMPLE_SWITCH)
        else $error("sample switch closed too long");
    a_write_restart: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        wr_ctl |=> cyc_reg == 6'h0 && !ctl_reg.done)
        else $error("write did not restart conversion");
    a_mux_onehot: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (SAMPLE_SWITCH && ctl_reg.channel != CH_FACTORY)
            |-> MUX_SELECT == 7'h1 << ctl_reg.channel)
        else $error("channel select not one-hot");
    a_mux_idle: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !SAMPLE_SWITCH |-> MUX_SELECT == 7'h0)
        else $error("input connected outside sampling");
    a_stop_quiet: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        stop_sync_reg[1] |-> !RC_OSC_ENABLE && !conv_done && !SAMPLE_SWITCH)
        else $error("converter active in stop");
endmodule
`default_nettype wire

// [verif/analog_front_model.sv]
// behavioural analog front end: input pins, reference taps and comparator
`timescale 1ns/10ps
`default_nettype none
module analog_front_model (
    input  wire logic        clk,
    input  wire logic        sample_on,
    input  wire logic [6:0]  mux_sel,
    input  wire logic [7:0]  dac_code,
    input  wire logic [31:0] ext_levels,
    output logic             comp_out
);
    // ==========================================
    // sample and hold
    logic [7:0] held = 8'h00;

    function automatic logic [7:0] level(input int i);
        return i < 4 ? ext_levels[8*i +: 8] : i == 4 ? 8'hff : i == 5 ? 8'h80 : 8'h00;
    endfunction

    // no input selected leaves the capacitor floating, so it wanders each cycle
    always @(posedge clk) begin
        if (sample_on) begin
            held <= ~held;
            for (int i = 0; i < 7; i++)
                if (mux_sel[i]) held <= level(i);
        end
    end

    assign comp_out = held >= dac_code;
endmodule
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import adc_ctrl_pkg::*;
    // ==========================================
    // stimulus and wiring
    localparam logic [31:0] lvl = 32'hc4_5a_a5_3c;
    logic        clk = 0, rst = 1, rc = 0, rc_on = 0, wt = 0, st = 0, cmp;
    logic        rcen, ss, irq, awv = 0, awr, wv = 0, wrdy, bv, arv = 0, arr, rv;
    logic [7:0]  dac;
    logic [6:0]  mux;
    logic [1:0]  bresp, rresp;
    logic [3:0]  ws = 4'h1;
    logic [31:0] aw = 0, wd = 0, ar = 0, rdata, v;
    int          bad_count = 0, compares = 0, cyc = 0;

    always #2 clk = ~clk;
    always #7.3 if (rc_on) rc = ~rc;

    sar_adc_control uut (.CLOCK(clk), .SYS_RST(rst), .RC_CLK_TICK(rc), .WAIT_MODE(wt),
        .STOP_MODE(st), .COMP_OUT(cmp), .RC_OSC_ENABLE(rcen), .SAMPLE_SWITCH(ss),
        .DAC_CODE(dac), .MUX_SELECT(mux), .IRQ(irq), .S_AXI_AWADDR(aw),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1));

    analog_front_model fe (.clk(clk), .sample_on(ss), .mux_sel(mux), .dac_code(dac),
        .ext_levels(lvl), .comp_out(cmp));

    // ==========================================
    // tasks
    task automatic end_sim;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        aw <= {22'h0, i, 2'h0};
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
        end while (!bv);
        chk(bresp, 2'h0);
    endtask

    task automatic rd(input logic [7:0] i, output logic [31:0] d);
        ar <= {22'h0, i, 2'h0};
        arv <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
        end while (!rv);
        d = rdata;
        chk(rresp, 2'h0);
    endtask

    // completion time is not fixed under the rc clock, so the flag is polled
    task automatic poll;
        v = 0;
        for (int k = 0; k < 300 && !v[DONE_BIT]; k++) rd(STATCTL_IDX, v);
        chk(v[DONE_BIT], 1'b1);
    endtask

    function automatic logic [7:0] ev(input logic [2:0] c);
        return c < 4 ? lvl[8*c +: 8] : c == 4 ? 8'hff : c == 5 ? 8'h80 : 8'h00;
    endfunction

    task automatic mon(input logic [2:0] c);
        int n;
        int m;
        n = 0;
        m = 0;
        while (ss) @(posedge clk);
        while (!ss) @(posedge clk);
        chk(mux, c == 7 ? 7'h0 : 7'h1 << c);
        while (ss) begin
            n++;
            @(posedge clk);
        end
        while (!ss) begin
            m++;
            @(posedge clk);
        end
        chk(n, SAMPLE_CYCLES);
        chk(n + m, CONV_CYCLES);
    endtask

    task automatic idle_chk;
        int n;
        n = 0;
        repeat (40) begin
            @(posedge clk);
            n += ss;
        end
        chk(n, 0);
    endtask

    // ==========================================
    // tests
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(STATCTL_IDX, v);
        chk(v, {24'h0, STATCTL_RESET});
        chk({rcen, irq}, 2'b00);
        for (int c = 0; c < 8; c++) begin
            wt <= c[2];
            wr(STATCTL_IDX, 8'h20 | 8'(c));
            mon(3'(c));
            if (c < 7) begin
                poll();
                rd(RESULT_IDX, v);
                chk(v, {24'h0, ev(3'(c))});
                rd(STATCTL_IDX, v);
                chk(v[DONE_BIT], 1'b0);
            end
        end
        wr(STATCTL_IDX, 8'hb9);
        rd(STATCTL_IDX, v);
        chk(v, 32'h21);
        poll();
        wr(RESULT_IDX, 8'h5a);
        rd(RESULT_IDX, v);
        chk(v, {24'h0, ev(3'd1)});
        rd(IRQ_STAT_IDX, v);
        chk({v[0], irq}, 2'b10);
        wr(IRQ_EN_IDX, 8'h01);
        chk(irq, 1'b1);
        wr(STATCTL_IDX, 8'h00);
        wr(IRQ_CLR_IDX, 8'h01);
        rd(IRQ_STAT_IDX, v);
        chk({v[0], irq}, 2'b00);
        rd(8'h20, v);
        chk(v, 32'h0);
        // a write without byte lane 0 must leave the register alone
        ws <= 4'he;
        wr(STATCTL_IDX, 8'h25);
        rd(STATCTL_IDX, v);
        chk(v, 32'h0);
        ws <= 4'h1;
        // warm-up runs the oscillator only, as software does below 1 MHz
        wr(STATCTL_IDX, 8'h40);
        rc_on <= 1'b1;
        chk(rcen, 1'b1);
        idle_chk();
        wr(STATCTL_IDX, 8'h63);
        poll();
        rd(RESULT_IDX, v);
        chk(v, {24'h0, ev(3'd3)});
        rc_on <= 1'b0;
        wr(STATCTL_IDX, 8'h22);
        repeat (20) @(posedge clk);
        st <= 1'b1;
        idle_chk();
        rd(STATCTL_IDX, v);
        chk({v[DONE_BIT], rcen}, 2'b00);
        end_sim();
    end
endmodule
`default_nettype wire
